/* rpc_consts.svh */
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// ----------------------------------------
// Register offsets within one framer page
// ----------------------------------------
`define RPC_OFF_CFG     7'h50
`define RPC_OFF_STAT    7'h51
`define RPC_OFF_ACTL    7'h52
`define RPC_OFF_DBUF    7'h53
`define RPC_PAGE_W      3

// ----------------------------------------
// Indirect space
// ----------------------------------------
`define RPC_IA_CFG_LO   7'h01
`define RPC_IA_DTRK_LO  7'h19
`define RPC_IA_STRK_LO  7'h31
`define RPC_IA_HI       7'h48
`define RPC_NUM_CH      24

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RPC_B_RW        7
`define RPC_B_BUSY      7
`define RPC_B_GEN       0
`define RPC_B_INV       7
`define RPC_B_DATA_COND_ENABLE     6
`define RPC_B_DMW       5
`define RPC_B_MSBF      4
`define RPC_B_TEST      3
`define RPC_B_EXTR      2
`define RPC_B_FIX       1
`define RPC_B_POL       0
`define RPC_B_SIG_COND_ENABLE     7
`define RPC_RST_BYTE    8'h00

// ----------------------------------------
// Timing and milliwatt sequence
// ----------------------------------------
`define RPC_ACCESS_NS   640
`define RPC_CLK_NS      50
`define RPC_ACCESS_CYC  (`RPC_ACCESS_NS / `RPC_CLK_NS)
`define RPC_MW_SEQ      64'h1e0b0b1e9e8b8b9e

`endif

/* rpc_pkg.sv */
`include "rpc_consts.svh"

package rpc_pkg;

  typedef enum logic {IDLE, BUSY} phase_t;

  typedef struct packed {
    phase_t                            phase;
    logic [3:0]                        cnt;
    logic [7:0]                        actl;
    logic [7:0]                        dbuf;
    logic                              glb_en;
    logic [`RPC_NUM_CH-1:0][7:0]       cfg;
    logic [`RPC_NUM_CH-1:0][7:0]       dtrk;
    logic [`RPC_NUM_CH-1:0][7:0]       strk;
    logic [7:0]                        rdata;
    logic [7:0]                        sd_out;
    logic [3:0]                        sig_out;
    logic                              out_vld;
    logic                              sclk;
    logic [7:0]                        det_byte;
    logic                              det_vld;
    logic [2:0]                        mw_idx;
  } state_t;

endpackage

/* rx_payload_channel_ctrl.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "rpc_consts.svh"


module rx_payload_channel_ctrl #(
  parameter int FRAMER_IDX = 0
) (
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [9:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic             busy_o,
  // Received channel stream
  input  wire logic        ch_valid_i,
  input  wire logic [4:0]  ch_num_i,
  input  wire logic [7:0]  ch_data_i,
  input  wire logic [3:0]  ch_sig_i,
  input  wire logic        frac_mode_i,
  input  wire logic        pattern_direction_sel_i,
  // Pattern generator and detector
  input  wire logic [7:0]  gen_byte_i,
  output logic             gen_take_o,
  output logic      [7:0]  det_byte_o,
  output logic             det_valid_o,
  // System side outputs
  output logic             out_valid_o,
  output logic      [7:0]  rx_serial_data_out_o,
  output logic      [3:0]  rx_signaling_out_o,
  output logic             rx_slave_clock_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (FRAMER_IDX < 0 || FRAMER_IDX > 7) begin : g_bad_idx
    $error("FRAMER_IDX must be 0 to 7");
  end

  localparam logic [`RPC_PAGE_W-1:0] PAGE = `RPC_PAGE_W'(FRAMER_IDX);
  localparam logic [3:0]             CYC  = 4'(`RPC_ACCESS_CYC);
  localparam logic [63:0]            MW   = `RPC_MW_SEQ;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rs_ff;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs_ff <= 2'b00;
    end else begin
      rs_ff <= {rs_ff[0], 1'b1};
    end
  end

  assign rst_n = rs_ff[1];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  rpc_pkg::state_t s_ff;
  rpc_pkg::state_t nxt_s;
  logic       hit;
  logic [6:0] off;
  logic [6:0] ia;
  logic       ia_cfg;
  logic       ia_dtrk;
  logic       ia_strk;
  logic       ia_ok;
  logic [4:0] ia_idx;
  logic [7:0] ia_rd;
  logic       ch_ok;
  logic       act;
  logic [7:0] cc;
  logic [7:0] dt;
  logic [7:0] st;
  logic [7:0] mw_byte;
  logic       launch;

  // Each framer answers only inside its own page.
  // framer page decode
  assign hit = (addr_i[9:7] == PAGE);
  assign off = addr_i[6:0];

  assign ia      = s_ff.actl[6:0];
  assign ia_cfg  = (ia >= `RPC_IA_CFG_LO) && (ia < `RPC_IA_DTRK_LO);
  assign ia_dtrk = (ia >= `RPC_IA_DTRK_LO) && (ia < `RPC_IA_STRK_LO);
  assign ia_strk = (ia >= `RPC_IA_STRK_LO) && (ia <= `RPC_IA_HI);
  assign ia_ok   = ia_cfg || ia_dtrk || ia_strk;

  always_comb begin
    if (ia_cfg) begin
      ia_idx = 5'(ia - `RPC_IA_CFG_LO);
      ia_rd  = s_ff.cfg[ia_idx];
    end else if (ia_dtrk) begin
      ia_idx = 5'(ia - `RPC_IA_DTRK_LO);
      ia_rd  = s_ff.dtrk[ia_idx];
    end else if (ia_strk) begin
      ia_idx = 5'(ia - `RPC_IA_STRK_LO);
      ia_rd  = s_ff.strk[ia_idx];
    end else begin
      ia_idx = 5'h00;
      ia_rd  = `RPC_RST_BYTE;
    end
  end

  assign launch = wr_i && hit && (off == `RPC_OFF_ACTL) && (s_ff.phase == rpc_pkg::IDLE);

  // Channels above the table pass untouched.
  // global enable gate
  assign ch_ok = (ch_num_i < 5'(`RPC_NUM_CH));
  assign act   = ch_ok && s_ff.glb_en;
  assign cc    = ch_ok ? s_ff.cfg[ch_num_i] : `RPC_RST_BYTE;
  assign dt    = ch_ok ? s_ff.dtrk[ch_num_i] : `RPC_RST_BYTE;
  assign st    = ch_ok ? s_ff.strk[ch_num_i] : `RPC_RST_BYTE;
  assign mw_byte = MW[{~s_ff.mw_idx, 3'b000} +: 8];

  // One shared generator feed keeps replaced channels in one sequence.
  // shared generator stream
  assign gen_take_o = ce_i && ch_valid_i && act && cc[`RPC_B_TEST] && pattern_direction_sel_i
                      && !cc[`RPC_B_DATA_COND_ENABLE] && !cc[`RPC_B_DMW];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.rdata   = `RPC_RST_BYTE;
    nxt_s.det_vld = 1'b0;
    nxt_s.sclk    = 1'b0;
    nxt_s.out_vld = ch_valid_i;

    if (wr_i && hit) begin
      if (off == `RPC_OFF_CFG) begin
        nxt_s.glb_en = wdata_i[`RPC_B_GEN];
      end else if (launch) begin
        nxt_s.actl  = wdata_i;
        nxt_s.phase = rpc_pkg::BUSY;
        nxt_s.cnt   = CYC;
      end else if (off == `RPC_OFF_DBUF) begin
        nxt_s.dbuf = wdata_i;
      end
    end

    if (rd_i && hit) begin
      if (off == `RPC_OFF_CFG) begin
        nxt_s.rdata = {7'h00, s_ff.glb_en};
      end else if (off == `RPC_OFF_STAT) begin
        nxt_s.rdata = {s_ff.phase == rpc_pkg::BUSY, 7'h00};
      end else if (off == `RPC_OFF_ACTL) begin
        nxt_s.rdata = s_ff.actl;
      end else if (off == `RPC_OFF_DBUF) begin
        nxt_s.rdata = s_ff.dbuf;
      end
    end

    // The access completes on the last counted cycle, so while ce_i stays high a read result
    // never lands later than the documented access time.
    // busy until completion
    if (s_ff.phase == rpc_pkg::BUSY) begin
      nxt_s.cnt = s_ff.cnt - 4'h1;
      if (s_ff.cnt == 4'h1) begin
        nxt_s.phase = rpc_pkg::IDLE;
        if (ia_ok) begin
          if (s_ff.actl[`RPC_B_RW]) begin
            nxt_s.dbuf = ia_rd;
          end else if (ia_cfg) begin
            nxt_s.cfg[ia_idx] = s_ff.dbuf;
          end else if (ia_dtrk) begin
            nxt_s.dtrk[ia_idx] = s_ff.dbuf;
          end else begin
            nxt_s.strk[ia_idx] = s_ff.dbuf;
          end
        end
      end
    end

    if (ch_valid_i) begin
      if (ch_num_i == 5'h00) begin
        nxt_s.mw_idx = s_ff.mw_idx + 3'h1;
      end
      nxt_s.sd_out  = ch_data_i;
      nxt_s.sig_out = ch_sig_i;
      nxt_s.sclk    = frac_mode_i && (!act || cc[`RPC_B_EXTR]);
      if (act) begin
        if (cc[`RPC_B_TEST] && !pattern_direction_sel_i) begin
          nxt_s.det_byte = ch_data_i;
          nxt_s.det_vld  = 1'b1;
        end else if (cc[`RPC_B_DATA_COND_ENABLE]) begin
          nxt_s.sd_out = dt;
        end else if (cc[`RPC_B_DMW]) begin
          nxt_s.sd_out = mw_byte;
        end else if (cc[`RPC_B_TEST]) begin
          nxt_s.sd_out = gen_byte_i;
        end else begin
          nxt_s.sd_out = ch_data_i ^ {cc[`RPC_B_INV] ^ cc[`RPC_B_MSBF], {7{cc[`RPC_B_INV]}}};
          if (cc[`RPC_B_FIX]) begin
            nxt_s.sd_out[0] = cc[`RPC_B_POL];
          end
        end
        if (st[`RPC_B_SIG_COND_ENABLE]) begin
          nxt_s.sig_out = st[3:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o              = s_ff.rdata;
  assign busy_o               = (s_ff.phase == rpc_pkg::BUSY);
  assign det_byte_o           = s_ff.det_byte;
  assign det_valid_o          = s_ff.det_vld;
  assign out_valid_o          = s_ff.out_vld;
  assign rx_serial_data_out_o = s_ff.sd_out;
  assign rx_signaling_out_o   = s_ff.sig_out;
  assign rx_slave_clock_o     = s_ff.sclk;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  a_launch_busy: assert property (ce_i && launch |=> busy_o && s_ff.cnt == CYC)
    else $error("access did not start");

  a_busy_clear: assert property (ce_i && busy_o && s_ff.cnt == 4'h1 |=> !busy_o)
    else $error("busy did not clear");

  a_read_load: assert property (ce_i && busy_o && s_ff.cnt == 4'h1 && ia_ok && s_ff.actl[7]
                                |=> s_ff.dbuf == $past(ia_rd))
    else $error("read byte not loaded");

  a_write_store: assert property (ce_i && busy_o && s_ff.cnt == 4'h1 && ia_ok && !s_ff.actl[7]
                                  |=> ia_rd == $past(s_ff.dbuf))
    else $error("write byte not stored");

  a_bad_addr: assert property (ce_i && busy_o && !ia_ok
                               |=> s_ff.cfg == $past(s_ff.cfg) && s_ff.dtrk == $past(s_ff.dtrk)
                                   && s_ff.strk == $past(s_ff.strk))
    else $error("bad address changed a register");

  a_dis_pass: assert property (ce_i && ch_valid_i && !s_ff.glb_en
                               |=> rx_serial_data_out_o == $past(ch_data_i))
    else $error("disabled channel altered");

  a_dis_sig: assert property (ce_i && ch_valid_i && !s_ff.glb_en
                              |=> rx_signaling_out_o == $past(ch_sig_i))
    else $error("disabled signaling altered");

  a_trunk_wins: assert property (ce_i && ch_valid_i && act && cc[6] && !cc[3]
                                 |=> rx_serial_data_out_o == $past(dt))
    else $error("trunk byte not applied");

  a_sig_cond: assert property (ce_i && ch_valid_i && act && st[7]
                               |=> rx_signaling_out_o == $past(st[3:0]))
    else $error("signaling nibble not applied");

  a_gen_take: assert property (gen_take_o |=> rx_serial_data_out_o == $past(gen_byte_i))
    else $error("generated byte not used");

  a_inv_apply: assert property (ce_i && ch_valid_i && act && cc[6:5] == 2'b00 && !cc[3] && !cc[1]
                                |=> rx_serial_data_out_o[6:0] == ($past(ch_data_i[6:0]) ^ {7{$past(cc[7])}})
                                    && rx_serial_data_out_o[7] == ($past(ch_data_i[7]) ^ $past(cc[7] ^ cc[4])))
    else $error("inversion not applied");

  a_sig_force: assert property (ce_i && ch_valid_i && act && cc[6:5] == 2'b00 && !cc[3] && cc[1]
                                |=> rx_serial_data_out_o[0] == $past(cc[0]))
    else $error("signaling bit not forced");

  a_mw_apply: assert property (ce_i && ch_valid_i && act && !cc[6] && cc[5]
                               && !(cc[3] && !pattern_direction_sel_i)
                               |=> rx_serial_data_out_o inside {8'h1e, 8'h0b, 8'h8b, 8'h9e})
    else $error("milliwatt byte not applied");

  a_det_route: assert property (ce_i && ch_valid_i && act && cc[3] && !pattern_direction_sel_i
                                |=> det_valid_o && det_byte_o == $past(ch_data_i)
                                    && rx_serial_data_out_o == $past(ch_data_i))
    else $error("detector routing not applied");

  a_slave_clk: assert property (ce_i && ch_valid_i && frac_mode_i && act
                                |=> rx_slave_clock_o == $past(cc[2]))
    else $error("slave clock gate not applied");

  a_busy_refuse: assert property (ce_i && busy_o && wr_i && hit && off == `RPC_OFF_ACTL
                                  |=> $stable(s_ff.actl))
    else $error("launch accepted while busy");

  a_ce_freeze: assert property (!ce_i |=> $stable(s_ff))
    else $error("state moved while disabled");

  a_out_valid: assert property (ce_i |=> out_valid_o == $past(ch_valid_i))
    else $error("output valid misaligned");

endmodule // rx_payload_channel_ctrl

/* rpc_sys_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// System side: pattern source and sink
// ----------------------------------------
module rpc_sys_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Pattern generator stream
  input  wire logic       gen_take_i,
  output logic      [7:0] gen_byte_o,
  // Conditioned stream
  input  wire logic       out_valid_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] last_byte_o
);
  // one continuous sequence
  // The source only steps when a byte is taken, so a skipped or doubled take shows as a gap.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_byte_o  <= 8'h11;
      last_byte_o <= 8'h00;
    end else begin
      if (gen_take_i) begin
        gen_byte_o <= gen_byte_o + 8'h01;
      end
      if (out_valid_i) begin
        last_byte_o <= data_i;
      end
    end
  end
endmodule // rpc_sys_model

/* test_rx_payload_channel_ctrl.sv */
`timescale 1ns/1ps

module test_rx_payload_channel_ctrl;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce    = 1'b1;
  logic [9:0] addr  = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       vld   = 1'b0;
  logic [4:0] num   = 5'h00;
  logic [7:0] din   = 8'h00;
  logic [3:0] sin   = 4'h0;
  logic       frac  = 1'b0;
  logic       psel  = 1'b0;
  logic [7:0] rdata, gbyte, dbyte, sd, last;
  logic [3:0] sg;
  logic       busy, take, dvld, ov, sck;
  int         mismatches = 0;
  int         n_compared = 0;

  always #25 clk = ~clk;

  rx_payload_channel_ctrl #(.FRAMER_IDX(1)) DUT (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .busy_o(busy), .ch_valid_i(vld), .ch_num_i(num), .ch_data_i(din), .ch_sig_i(sin),
    .frac_mode_i(frac), .pattern_direction_sel_i(psel), .gen_byte_i(gbyte), .gen_take_o(take),
    .det_byte_o(dbyte), .det_valid_o(dvld), .out_valid_o(ov), .rx_serial_data_out_o(sd),
    .rx_signaling_out_o(sg), .rx_slave_clock_o(sck));

  rpc_sys_model sys (.ref_clk_i(clk), .rst_n_i(rst_n), .gen_take_i(take), .gen_byte_o(gbyte),
    .out_valid_i(ov), .data_i(sd), .last_byte_o(last));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // A launch with a bad address still raises busy for the full count, but with good low its timing is only polled.
  task automatic ind(input logic [7:0] ac, input logic [7:0] d, input logic good);
    int n;
    n = 1;
    wr_reg(10'h0d3, d);
    wr_reg(10'h0d2, ac);
    #1 if (good) chk(busy, 1'b1);
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    if (good) chk(n <= 13, 1'b1);
  endtask

  task automatic send(input logic [4:0] ch, input logic [7:0] d, input logic [3:0] s, input logic [7:0] exp);
    @(posedge clk);
    vld <= 1'b1;
    num <= ch;
    din <= d;
    sin <= s;
    @(posedge clk);
    vld <= 1'b0;
    #1 chk(ov, 1'b1);
    if (exp !== 8'hxx) chk(sd, exp);
  endtask

  task automatic t_regs;
    rd_reg(10'h0d2, 8'h00);
    rd_reg(10'h0d3, 8'h00);
    rd_reg(10'h0d5, 8'h00);
    wr_reg(10'h052, 8'h81);
    #1 chk(busy, 1'b0);
    rd_reg(10'h0d2, 8'h00);
  endtask

  task automatic t_indirect;
    ind(8'h05, 8'ha5, 1'b1);
    ind(8'h85, 8'hee, 1'b1);
    rd_reg(10'h0d3, 8'ha5);
    ind(8'h49, 8'h5c, 1'b0);
    ind(8'h00, 8'h5c, 1'b0);
    ind(8'hc8, 8'hee, 1'b1);
    rd_reg(10'h0d3, 8'h00);
  endtask

  task automatic t_data_ops;
    logic [7:0] flip [4] = '{8'h00, 8'h80, 8'hff, 8'h7f};
    wr_reg(10'h0d0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      ind(8'h01, {i[1], 2'b00, i[0], 4'h0}, 1'b1);
      send(5'd0, 8'h5a, 4'h0, 8'h5a ^ flip[i]);
    end
    ind(8'h82, 8'h00, 1'b0);
    ind(8'h01, 8'h82, 1'b1);
    send(5'd0, 8'h5a, 4'h0, 8'ha4);
    ind(8'h01, 8'h03, 1'b1);
    send(5'd0, 8'h5a, 4'h0, 8'h5b);
    ind(8'h19, 8'h3c, 1'b1);
    ind(8'h01, 8'he0, 1'b1);
    send(5'd0, 8'h5a, 4'h0, 8'h3c);
    ind(8'h01, 8'h20, 1'b1);
    // This is the eighth frame start since reset, so the phase sits on the last byte and then wraps.
    send(5'd0, 8'h5a, 4'h0, 8'h9e);
    chk(sd inside {8'h1e, 8'h0b, 8'h8b, 8'h9e}, 1'b1);
    send(5'd0, 8'h5a, 4'h0, 8'h1e);
  endtask

  task automatic t_routing;
    logic [7:0] e;
    @(posedge clk);
    psel <= 1'b1;
    ind(8'h01, 8'h08, 1'b1);
    e = gbyte;
    send(5'd0, 8'h5a, 4'h0, e);
    send(5'd0, 8'h5a, 4'h0, e + 8'h01);
    @(posedge clk);
    psel <= 1'b0;
    ind(8'h01, 8'h48, 1'b1);
    send(5'd0, 8'h5a, 4'h0, 8'h5a);
    chk(dvld, 1'b1);
    chk(dbyte, 8'h5a);
  endtask

  task automatic t_signaling;
    @(posedge clk);
    frac <= 1'b1;
    ind(8'h01, 8'h04, 1'b1);
    send(5'd0, 8'h5a, 4'h3, 8'h5a);
    chk(sck, 1'b1);
    ind(8'h01, 8'h00, 1'b1);
    send(5'd0, 8'h5a, 4'h3, 8'h5a);
    chk(sck, 1'b0);
    chk(sg, 4'h3);
    ind(8'h31, 8'h8a, 1'b1);
    send(5'd0, 8'h5a, 4'h3, 8'h5a);
    chk(sg, 4'ha);
    ind(8'h01, 8'hff, 1'b1);
    wr_reg(10'h0d0, 8'h00);
    send(5'd0, 8'h5a, 4'h3, 8'h5a);
    chk(sg, 4'h3);
  endtask

  // A low clock enable must swallow a channel byte and a launch alike.
  task automatic t_freeze;
    @(posedge clk);
    ce    <= 1'b0;
    vld   <= 1'b1;
    din   <= 8'hc3;
    addr  <= 10'h0d2;
    wdata <= 8'h01;
    wr    <= 1'b1;
    @(posedge clk);
    ce    <= 1'b1;
    vld   <= 1'b0;
    wr    <= 1'b0;
    #1 chk(ov, 1'b0);
    chk(sd, 8'h5a);
    chk(busy, 1'b0);
    chk(last, 8'h5a);
  endtask

  // The second launch lands inside the busy time and must leave the first one untouched.
  task automatic t_refuse;
    wr_reg(10'h0d2, 8'h81);
    wr_reg(10'h0d2, 8'h05);
    rd_reg(10'h0d1, 8'h80);
    rd_reg(10'h0d2, 8'h81);
    repeat (12) @(posedge clk);
    rd_reg(10'h0d1, 8'h00);
    rd_reg(10'h0d3, 8'hff);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The run needs under two thousand cycles; the limit leaves ample room.
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_indirect;
    t_data_ops;
    t_routing;
    t_signaling;
    t_freeze;
    t_refuse;
    print_verdict;
  end
endmodule // test_rx_payload_channel_ctrl
